// >>> hw/sldu_pkg.sv
// Constants and types for the signed load unit
// Assumes issue logic supplies decoded opcode fields and the data cache answers in fixed time
package sldu_pkg;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned OPC_W        = 8;
  localparam int unsigned MOD_W        = 7;
  localparam int unsigned DEST_W       = 7;
  localparam int unsigned SLOT_W       = 3;
  localparam logic [OPC_W-1:0] OPC_BYTE_DISP  = 8'hC0;
  localparam logic [OPC_W-1:0] OPC_BYTE_INDEX = 8'hC1;
  localparam logic [OPC_W-1:0] OPC_HALF_SCALE = 8'hC4;
  localparam logic [SLOT_W-1:0] SLOT_FOUR     = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_FIVE     = 3'h5;
  localparam int unsigned LOAD_LATENCY = 3;
  localparam logic [DATA_W-1:0] WINDOW_BASE = 32'hEFE00000;
  localparam logic [DATA_W-1:0] WINDOW_MASK = 32'hFFE00000;
  typedef enum logic [2:0] {
    SLDU_KIND_NONE = 3'h1,
    SLDU_KIND_BYTE = 3'h2,
    SLDU_KIND_HALF = 3'h4
  } sldu_kind_e;
endpackage : sldu_pkg

// >>> hw/sldu_extend.sv
// Byte lane select and sign extension of returned data
// Assumes cache returns a 16-bit pair: lane 0 from address, lane 1 from address plus one
`timescale 1ns/100ps
`default_nettype none
module sldu_extend
  import sldu_pkg::*;
(
  input  wire logic [15:0]       pairData,
  input  wire logic              isHalf,
  input  wire logic              bigEndian,
  output logic      [DATA_W-1:0] extended
);
  logic [15:0] ordered;
  always_comb begin
    ordered = bigEndian ? {pairData[7:0], pairData[15:8]} : pairData;
    if (isHalf) begin
      extended = {{16{ordered[15]}}, ordered};
    end else begin
      extended = {{24{pairData[7]}}, pairData[7:0]};
    end
  end
endmodule // sldu_extend
`default_nettype wire

// >>> hw/sldu_load_unit.sv
// Signed load unit: address formation, cache request, three-stage result pipeline
// Assumes issue logic presents one op per cycle and cache data returns one cycle after request
`timescale 1ns/100ps
`default_nettype none
module sldu_load_unit
  import sldu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              issueValid,
  input  wire logic [OPC_W-1:0]  opcode,
  input  wire logic [MOD_W-1:0]  modifier,
  input  wire logic [SLOT_W-1:0] issueSlot,
  input  wire logic              guardPresent,
  input  wire logic [DATA_W-1:0] guardValue,
  input  wire logic [DATA_W-1:0] firstSourceRegister,
  input  wire logic [DATA_W-1:0] secondSourceRegister,
  input  wire logic [DEST_W-1:0] destIndex,
  input  wire logic              bigEndianFlag,
  input  wire logic [15:0]       cacheData,
  output logic                   cacheReq,
  output logic      [DATA_W-1:0] cacheAddr,
  output logic                   cacheHalf,
  output logic                   resultWrite,
  output logic      [DEST_W-1:0] resultDest,
  output logic      [DATA_W-1:0] resultData,
  output logic                   windowAccess,
  output logic                   illegalIssue
);
  typedef struct packed {
    logic              reqV;
    logic [DATA_W-1:0] addr;
    logic              half;
    logic              big;
    logic [DEST_W-1:0] dst;
    logic              midV;
    logic              midHalf;
    logic              midBig;
    logic [DEST_W-1:0] midDst;
    logic              wr;
    logic [DEST_W-1:0] wrDst;
    logic [DATA_W-1:0] wrData;
    logic              win;
    logic              bad;
  } sldu_state_s;

  sldu_state_s st;
  sldu_state_s next_st;
  sldu_kind_e  kind;
  logic        guardOk;
  logic        slotOk;
  logic        fire;
  logic [DATA_W-1:0] addr;
  logic [DATA_W-1:0] extended;

  sldu_extend u_extend (
    .pairData  (cacheData),
    .isHalf    (st.midHalf),
    .bigEndian (st.midBig),
    .extended  (extended)
  );

  always_comb begin
    case (opcode)
      OPC_BYTE_DISP:  kind = SLDU_KIND_BYTE;
      OPC_BYTE_INDEX: kind = SLDU_KIND_BYTE;
      OPC_HALF_SCALE: kind = SLDU_KIND_HALF;
      default:        kind = SLDU_KIND_NONE;
    endcase
    guardOk = !guardPresent || guardValue[0];
    slotOk = (issueSlot == SLOT_FOUR) || (issueSlot == SLOT_FIVE);
    fire = issueValid && slotOk && guardOk && (kind != SLDU_KIND_NONE);
    if (opcode == OPC_BYTE_DISP) begin
      addr = firstSourceRegister + {{(DATA_W-MOD_W){modifier[MOD_W-1]}}, modifier};
    end else if (opcode == OPC_BYTE_INDEX) begin
      addr = firstSourceRegister + secondSourceRegister;
    end else begin
      addr = firstSourceRegister + {secondSourceRegister[DATA_W-2:0], 1'b0};
    end
  end

  always_comb begin
    next_st         = st;
    next_st.reqV    = fire;
    next_st.addr    = fire ? addr : st.addr;
    next_st.half    = fire ? (kind == SLDU_KIND_HALF) : st.half;
    next_st.big     = fire ? bigEndianFlag : st.big;
    next_st.dst     = fire ? destIndex : st.dst;
    next_st.midV    = st.reqV;
    next_st.midHalf = st.half;
    next_st.midBig  = st.big;
    next_st.midDst  = st.dst;
    next_st.wr      = st.midV;
    next_st.wrDst   = st.midDst;
    next_st.wrData  = st.midV ? extended : st.wrData;
    next_st.win     = fire && ((addr & WINDOW_MASK) == WINDOW_BASE);
    next_st.bad     = issueValid && (kind != SLDU_KIND_NONE) && !slotOk;
    if (!rst_b) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign cacheReq     = st.reqV;
  assign cacheAddr    = st.addr;
  assign cacheHalf    = st.half;
  assign resultWrite  = st.wr;
  assign resultDest   = st.wrDst;
  assign resultData   = st.wrData;
  assign windowAccess = st.win;
  assign illegalIssue = st.bad;

  property p_latency;
    @(posedge clk) disable iff (!rst_b)
      fire |-> ##3 resultWrite;
  endproperty
  a_latency: assert property (p_latency) else $error("result not three cycles after issue");

  property p_guard_off;
    @(posedge clk) disable iff (!rst_b)
      (issueValid && guardPresent && !guardValue[0]) |=> !cacheReq;
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("cache touched with false guard");

  property p_guard_on;
    @(posedge clk) disable iff (!rst_b)
      (issueValid && slotOk && guardPresent && guardValue[0] && kind != SLDU_KIND_NONE) |=> cacheReq;
  endproperty
  a_guard_on: assert property (p_guard_on) else $error("true guard did not request");

  property p_noguard;
    @(posedge clk) disable iff (!rst_b)
      (issueValid && slotOk && !guardPresent && opcode == OPC_BYTE_DISP) |=> cacheReq;
  endproperty
  a_noguard: assert property (p_noguard) else $error("unguarded op not executed");

  property p_scaled;
    @(posedge clk) disable iff (!rst_b)
      (fire && opcode == OPC_HALF_SCALE)
        |=> cacheAddr == $past(firstSourceRegister) + ($past(secondSourceRegister) << 1);
  endproperty
  a_scaled: assert property (p_scaled) else $error("scaled address wrong");

  property p_disp;
    @(posedge clk) disable iff (!rst_b)
      (fire && opcode == OPC_BYTE_DISP)
        |=> cacheAddr == $past(firstSourceRegister) + DATA_W'($signed($past(modifier)));
  endproperty
  a_disp: assert property (p_disp) else $error("displacement address wrong");

  property p_index;
    @(posedge clk) disable iff (!rst_b)
      (fire && opcode == OPC_BYTE_INDEX) |=> cacheAddr == $past(firstSourceRegister) + $past(secondSourceRegister);
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  property p_slot;
    @(posedge clk) disable iff (!rst_b)
      (issueValid && !slotOk) |=> !cacheReq;
  endproperty
  a_slot: assert property (p_slot) else $error("issue from illegal slot executed");

  property p_byte_ext;
    @(posedge clk) disable iff (!rst_b)
      (st.midV && !st.midHalf) |=> resultData == {{24{$past(cacheData[7])}}, $past(cacheData[7:0])};
  endproperty
  a_byte_ext: assert property (p_byte_ext) else $error("byte extension or order wrong");

  property p_half_le;
    @(posedge clk) disable iff (!rst_b)
      (st.midV && st.midHalf && !st.midBig) |=> resultData[15:0] == $past(cacheData);
  endproperty
  a_half_le: assert property (p_half_le) else $error("little-endian half wrong");

  property p_half_be;
    @(posedge clk) disable iff (!rst_b)
      (st.midV && st.midHalf && st.midBig)
        |=> resultData[15:0] == {$past(cacheData[7:0]), $past(cacheData[15:8])};
  endproperty
  a_half_be: assert property (p_half_be) else $error("big-endian half wrong");

  property p_half_sign;
    @(posedge clk) disable iff (!rst_b)
      (st.midV && st.midHalf) |=> resultData[31:16] == {16{resultData[15]}};
  endproperty
  a_half_sign: assert property (p_half_sign) else $error("half not sign-extended");

  property p_byte_sign;
    @(posedge clk) disable iff (!rst_b)
      (st.midV && !st.midHalf) |=> resultData[31:8] == {24{resultData[7]}};
  endproperty
  a_byte_sign: assert property (p_byte_sign) else $error("byte not sign-extended");

  property p_dest;
    @(posedge clk) disable iff (!rst_b)
      fire |-> ##3 (resultDest == $past(destIndex, 3));
  endproperty
  a_dest: assert property (p_dest) else $error("result written to wrong destination");

  property p_off_nowrite;
    @(posedge clk) disable iff (!rst_b)
      (issueValid && guardPresent && !guardValue[0]) |-> ##3 !resultWrite;
  endproperty
  a_off_nowrite: assert property (p_off_nowrite) else $error("false guard wrote destination");

  property p_data_hold;
    @(posedge clk) disable iff (!rst_b)
      !resultWrite |-> $stable(resultData);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("result data moved without write");

  property p_dest_hold;
    @(posedge clk) disable iff (!rst_b)
      !resultWrite |-> $stable(resultDest);
  endproperty
  a_dest_hold: assert property (p_dest_hold) else $error("result destination moved without write");

  property p_addr_hold;
    @(posedge clk) disable iff (!rst_b)
      !cacheReq |-> $stable(cacheAddr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("cache address moved without request");

  property p_half_hold;
    @(posedge clk) disable iff (!rst_b)
      !cacheReq |-> $stable(cacheHalf);
  endproperty
  a_half_hold: assert property (p_half_hold) else $error("cache size moved without request");

  property p_window;
    @(posedge clk) disable iff (!rst_b)
      (fire && opcode == OPC_BYTE_DISP
        && (((firstSourceRegister + DATA_W'($signed(modifier))) & WINDOW_MASK) == WINDOW_BASE)) |=> windowAccess;
  endproperty
  a_window: assert property (p_window) else $error("window access not flagged");

  property p_window_exec;
    @(posedge clk) disable iff (!rst_b)
      windowAccess |-> cacheReq;
  endproperty
  a_window_exec: assert property (p_window_exec) else $error("window flag without executed load");

  property p_bad_flag;
    @(posedge clk) disable iff (!rst_b)
      (issueValid && (kind != SLDU_KIND_NONE) && !slotOk) |=> illegalIssue;
  endproperty
  a_bad_flag: assert property (p_bad_flag) else $error("illegal slot not flagged");

  property p_no_fault;
    @(posedge clk) disable iff (!rst_b)
      (issueValid && slotOk) |=> !illegalIssue;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("fault raised for legal slot");

  property p_unknown_op;
    @(posedge clk) disable iff (!rst_b)
      (issueValid && (kind == SLDU_KIND_NONE)) |=> (!cacheReq && !illegalIssue);
  endproperty
  a_unknown_op: assert property (p_unknown_op) else $error("foreign opcode executed");

  property p_req_next;
    @(posedge clk) disable iff (!rst_b)
      fire |=> cacheReq;
  endproperty
  a_req_next: assert property (p_req_next) else $error("request not one cycle after issue");

  property p_req_only;
    @(posedge clk) disable iff (!rst_b)
      !fire |=> !cacheReq;
  endproperty
  a_req_only: assert property (p_req_only) else $error("request without executed load");

  property p_wr_only;
    @(posedge clk) disable iff (!rst_b)
      resultWrite |-> $past(cacheReq, 2);
  endproperty
  a_wr_only: assert property (p_wr_only) else $error("write without earlier request");

  property p_half_kind;
    @(posedge clk) disable iff (!rst_b)
      (fire && (kind == SLDU_KIND_HALF)) |=> cacheHalf;
  endproperty
  a_half_kind: assert property (p_half_kind) else $error("half load not sized 16 bits");

  property p_byte_kind;
    @(posedge clk) disable iff (!rst_b)
      (fire && (kind == SLDU_KIND_BYTE)) |=> !cacheHalf;
  endproperty
  a_byte_kind: assert property (p_byte_kind) else $error("byte load not sized 8 bits");

  property p_odd_half;
    @(posedge clk) disable iff (!rst_b)
      (fire && opcode == OPC_HALF_SCALE && firstSourceRegister[0]) |=> !illegalIssue ##2 resultWrite;
  endproperty
  a_odd_half: assert property (p_odd_half) else $error("odd half address faulted");

  property p_order_big;
    @(posedge clk) disable iff (!rst_b)
      (fire && (kind == SLDU_KIND_HALF) && bigEndianFlag) |-> ##3 (resultData[7:0] == $past(cacheData[15:8]));
  endproperty
  a_order_big: assert property (p_order_big) else $error("issue-time big order not applied");

  property p_order_little;
    @(posedge clk) disable iff (!rst_b)
      (fire && (kind == SLDU_KIND_HALF) && !bigEndianFlag) |-> ##3 (resultData[7:0] == $past(cacheData[7:0]));
  endproperty
  a_order_little: assert property (p_order_little) else $error("issue-time little order not applied");
endmodule // sldu_load_unit
`default_nettype wire

// >>> verification/sldu_cache_model.sv
// Data cache model facing the signed load unit
// Assumes each request is answered with its byte pair one cycle later
`timescale 1ns/100ps
`default_nettype none
module sldu_cache_model (
  input  wire logic        clk,
  input  wire logic        cacheReq,
  input  wire logic [31:0] cacheAddr,
  output logic      [15:0] cacheData
);
  function automatic logic [7:0] memByte(input logic [31:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  initial cacheData = 16'h0000;
  // Pair valid one cycle after request, scrambled otherwise
  always @(posedge clk) begin
    if (cacheReq) begin
      cacheData <= {memByte(cacheAddr + 32'h1), memByte(cacheAddr)};
    end else begin
      cacheData <= ~cacheData;
    end
  end
endmodule // sldu_cache_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the signed load unit
// Assumes the fixed three-cycle result timing of the unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import sldu_pkg::*;
;
  logic              clk = 1'b0, rst_b = 1'b0, issueValid = 1'b0, guardPresent = 1'b0, bigEndianFlag = 1'b0;
  logic [OPC_W-1:0]  opcode = '0;
  logic [MOD_W-1:0]  modifier = '0;
  logic [SLOT_W-1:0] issueSlot = '0;
  logic [DATA_W-1:0] guardValue = '0, firstSourceRegister = '0, secondSourceRegister = '0;
  logic [DEST_W-1:0] destIndex = '0;
  wire logic [15:0]  cacheData;
  logic              cacheReq, cacheHalf, resultWrite, windowAccess, illegalIssue;
  logic [DATA_W-1:0] cacheAddr, resultData;
  logic [DEST_W-1:0] resultDest;
  int                mismatches = 0;
  int                n_checks = 0;
  always #2 clk = ~clk;
  sldu_load_unit i_sldu_load_unit (.clk, .rst_b, .issueValid, .opcode, .modifier, .issueSlot, .guardPresent,
    .guardValue, .firstSourceRegister, .secondSourceRegister, .destIndex, .bigEndianFlag, .cacheData,
    .cacheReq, .cacheAddr, .cacheHalf, .resultWrite, .resultDest, .resultData, .windowAccess, .illegalIssue);
  sldu_cache_model i_sldu_cache_model (.clk, .cacheReq, .cacheAddr, .cacheData);
  function automatic logic [7:0] memByte(input logic [31:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Issue one op and judge request, latency, result and flags
  task automatic op(input logic [7:0] opc, input logic [6:0] m, input logic [31:0] a, b, input logic be, gp, g,
                    input logic [2:0] sl, input logic [31:0] ea, input logic eh, ew, ex);
    logic [7:0]  b0, b1;
    logic [15:0] d;
    logic        ill, seen, win;
    b0 = memByte(ea);
    b1 = memByte(ea + 32'h1);
    d = eh ? (be ? {b0, b1} : {b1, b0}) : {{8{b0[7]}}, b0};
    win = ew && ((ea & WINDOW_MASK) === WINDOW_BASE);
    @(negedge clk);
    issueValid = 1'b1;
    opcode = opc;
    modifier = m;
    firstSourceRegister = a;
    secondSourceRegister = b;
    bigEndianFlag = be;
    guardPresent = gp;
    guardValue = {31'h0, g};
    issueSlot = sl;
    destIndex = destIndex + 7'h1;
    @(negedge clk);
    issueValid = 1'b0;
    `CHK(cacheReq, ew)
    if (ew) `CHK({cacheHalf, cacheAddr}, {eh, ea})
    ill = illegalIssue;
    seen = windowAccess;
    @(negedge clk);
    `CHK(resultWrite, 1'b0)
    ill |= illegalIssue;
    seen |= windowAccess;
    @(negedge clk);
    `CHK(resultWrite, ew)
    if (ew && !win && !(eh && ea[0])) `CHK({resultDest, resultData}, {destIndex, {{16{d[15]}}, d}})
    `CHK({ill | illegalIssue, seen | windowAccess}, {ex, win})
  endtask
  task automatic s_half();
    op(OPC_HALF_SCALE, 7'h0, 32'h1D4, 32'hFFFFFFFE, 1'b0, 1'b0, 1'b0, SLOT_FOUR, 32'h1D0, 1'b1, 1'b1, 1'b0);
    op(OPC_HALF_SCALE, 7'h0, 32'h1D4, 32'hFFFFFFFE, 1'b1, 1'b0, 1'b0, SLOT_FIVE, 32'h1D0, 1'b1, 1'b1, 1'b0);
    op(OPC_HALF_SCALE, 7'h0, 32'h101, 32'h1, 1'b0, 1'b0, 1'b0, SLOT_FOUR, 32'h103, 1'b1, 1'b1, 1'b0);
  endtask
  task automatic s_byte();
    op(OPC_BYTE_DISP, 7'h00, 32'h1D1, 32'h0, 1'b1, 1'b0, 1'b0, SLOT_FOUR, 32'h1D1, 1'b0, 1'b1, 1'b0);
    op(OPC_BYTE_DISP, 7'h40, 32'h211, 32'h0, 1'b0, 1'b0, 1'b0, SLOT_FOUR, 32'h1D1, 1'b0, 1'b1, 1'b0);
    op(OPC_BYTE_DISP, 7'h3F, 32'h100, 32'h0, 1'b1, 1'b0, 1'b0, SLOT_FIVE, 32'h13F, 1'b0, 1'b1, 1'b0);
    op(OPC_BYTE_INDEX, 7'h0, 32'h1C0, 32'h11, 1'b1, 1'b0, 1'b0, SLOT_FIVE, 32'h1D1, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic s_guard();
    op(OPC_BYTE_DISP, 7'h0, 32'h1D1, 32'h0, 1'b0, 1'b1, 1'b0, SLOT_FOUR, 32'h0, 1'b0, 1'b0, 1'b0);
    op(OPC_BYTE_DISP, 7'h0, 32'h1D1, 32'h0, 1'b0, 1'b1, 1'b1, SLOT_FOUR, 32'h1D1, 1'b0, 1'b1, 1'b0);
    op(OPC_HALF_SCALE, 7'h0, 32'h1D0, 32'h0, 1'b0, 1'b0, 1'b0, SLOT_FIVE, 32'h1D0, 1'b1, 1'b1, 1'b0);
  endtask
  task automatic s_refuse();
    op(OPC_BYTE_DISP, 7'h0, 32'h1D1, 32'h0, 1'b0, 1'b0, 1'b0, 3'h3, 32'h0, 1'b0, 1'b0, 1'b1);
    op(8'hC2, 7'h0, 32'h1D1, 32'h0, 1'b0, 1'b0, 1'b0, SLOT_FOUR, 32'h0, 1'b0, 1'b0, 1'b0);
    op(OPC_BYTE_DISP, 7'h0, 32'hEFE00010, 32'h0, 1'b0, 1'b0, 1'b0, SLOT_FOUR, 32'hEFE00010, 1'b0, 1'b1, 1'b0);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    s_half();
    s_byte();
    s_guard();
    s_refuse();
    wrap_up();
  end
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
